// ### common/timer_mode_pkg.sv
// Purpose: constants and carrier types of the timer mode and pwm control slice
// Assumes: classic wishbone, 32-bit data, byte lane 0 carries the 8-bit registers
// Notes:   offsets are byte addresses, one aligned word per register
package timer_mode_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int unsigned ADR_W             = 8;
   localparam int unsigned DAT_W             = 32;
   localparam logic [7:0]  MODE_SELECT_OFS   = 8'h00;
   localparam logic [7:0]  FUNC_CONTROL_OFS  = 8'h04;
   localparam logic [7:0]  PIN_STATUS_OFS    = 8'h08;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned PHASE_COUNT_BIT   = 6;
   localparam int unsigned FLAG_DIR_BIT      = 5;
   localparam int unsigned PULSE_MODE_LSB    = 0;
   localparam int unsigned COMB_MODE_LSB     = 4;
   localparam int unsigned BUFFER_EN_LSB     = 0;
   localparam int unsigned FUNC_FIXED_BIT    = 6;
   localparam int unsigned CHANNELS          = 5;

   // ---------------------------------------------------------------
   // reset values and counter limits
   // ---------------------------------------------------------------
   localparam logic [4:0]  PULSE_MODE_RST    = 5'h00;
   localparam logic [1:0]  COMB_MODE_RST     = 2'h0;
   localparam logic [3:0]  BUFFER_EN_RST     = 4'h0;
   localparam logic [7:0]  FUNC_CONTROL_RD0  = 8'h40;
   localparam logic [15:0] COUNTER_MAX       = 16'hFFFF;
   localparam logic [15:0] COUNTER_MIN       = 16'h0000;

   typedef enum logic [1:0] {
      COMB_NORMAL,
      COMB_COMPLEMENTARY,
      COMB_RESET_SYNC
   } comb_mode_e;

   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [3:0]       sel;
      logic [DAT_W-1:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic             ack;
      logic [DAT_W-1:0] dat;
   } wb_rsp_s;

   typedef struct packed {
      logic             phase_count_select;
      logic             flag_direction_select;
      logic [4:0]       pulse_mode;
      logic [1:0]       combination_mode;
      logic [3:0]       buffer_enable;
      logic             ext_a_meta;
      logic             ext_a_sync;
      logic             ext_a_prev;
      logic             ext_b_meta;
      logic             ext_b_sync;
      logic             ext_b_prev;
      logic [15:0]      channel2_counter;
      logic             overflow_set;
      logic [4:0]       pin_level;
      logic             ack;
      logic [DAT_W-1:0] rd_data;
   } timer_state_s;

endpackage : timer_mode_pkg

// ### rtl/timer_mode_pwm_control.sv
// Purpose: mode control, channel 2 phase counter and pwm pin control of a five channel timer
// Assumes: count ticks, compare matches and clear requests arrive as one-cycle pulses from
//          the prescaler and compare datapaths; inputs other than ext_count_in_a and ext_count_in_b are synchronous to clk_sys
// Notes:   registers on classic wishbone, ack one cycle after the request
//
// Local design decisions: the Wishbone register port and the register offsets.
module timer_mode_pwm_control (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic                     standby,
   // register bus
   input  wire timer_mode_pkg::wb_req_s  wb_req,
   output timer_mode_pkg::wb_rsp_s       wb_rsp,
   // external count inputs
   input  wire logic                     ext_count_in_a,
   input  wire logic                     ext_count_in_b,
   // channel 2 counting
   input  wire logic                     count_run_ch2,
   input  wire logic                     count_tick_ch2,
   output logic [15:0]                   channel2_counter,
   output logic                          overflow_flag_set,
   // synchronized clear
   input  wire logic [4:0]               timer_sync_select,
   input  wire logic [4:0]               clear_request,
   output logic [4:0]                    counter_clear,
   // compare matches and pwm pins
   input  wire logic [4:0]               match_a,
   input  wire logic [4:0]               match_b,
   input  wire logic [4:0]               channel_a_pin_i,
   output logic [4:0]                    channel_a_pin_o,
   output logic [4:0]                    channel_a_pin_oe_n,
   // mode outputs to the datapaths
   output logic                          phase_count_select,
   output logic [4:0]                    pwm_active,
   output logic                          complementary_pwm,
   output logic                          reset_sync_pwm,
   output logic [3:0]                    buffer_enable
);
   import timer_mode_pkg::*;

   localparam timer_state_s STATE_RST = '0;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic comb_mode_e decode_comb(input logic [1:0] field);
      comb_mode_e m;
      case (field)
         2'h2:    m = COMB_COMPLEMENTARY;
         2'h3:    m = COMB_RESET_SYNC;
         default: m = COMB_NORMAL;
      endcase
      return m;
   endfunction : decode_comb

   // returns {step, up}; a move of both pins at once is dropped
   function automatic logic [1:0] quad_step(input logic a, input logic b,
                                            input logic a_moved, input logic b_moved);
      logic [1:0] r;
      r = 2'h0;
      if (a_moved && !b_moved) begin
         r = {1'b1, ~(a ^ b)};
      end else if (b_moved && !a_moved) begin
         r = {1'b1, a ^ b};
      end
      return r;
   endfunction : quad_step

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   timer_state_s st_q;
   timer_state_s st_d;
   comb_mode_e   comb_mode;
   logic         bus_hit;
   logic         bus_write;
   logic         a_moved;
   logic         b_moved;
   logic [1:0]   qstep;
   logic         step;
   logic         step_up;
   logic         wrap_up;
   logic         wrap_down;
   logic [DAT_W-1:0] rd_mux;

   assign comb_mode = decode_comb(st_q.combination_mode);

   // ---------------------------------------------------------------
   // synchronized clear
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         counter_clear[i] = clear_request[i] |
                            (timer_sync_select[i] & |(clear_request & timer_sync_select));
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      bus_hit   = wb_req.cyc & wb_req.stb;
      bus_write = bus_hit & wb_req.we & st_q.ack & wb_req.sel[0];
      rd_mux    = '0;
      a_moved   = 1'b0;
      b_moved   = 1'b0;
      qstep     = 2'h0;
      step      = 1'b0;
      step_up   = 1'b0;
      wrap_up   = 1'b0;
      wrap_down = 1'b0;

      // read mux, reserved bit 7 reads 0
      case (wb_req.adr)
         MODE_SELECT_OFS: begin
            rd_mux[PHASE_COUNT_BIT]                     = st_q.phase_count_select;
            rd_mux[FLAG_DIR_BIT]                        = st_q.flag_direction_select;
            rd_mux[PULSE_MODE_LSB +: CHANNELS]          = st_q.pulse_mode;
         end
         FUNC_CONTROL_OFS: begin
            rd_mux[7:0]                                 = FUNC_CONTROL_RD0;
            rd_mux[COMB_MODE_LSB +: 2]                  = st_q.combination_mode;
            rd_mux[BUFFER_EN_LSB +: 4]                  = st_q.buffer_enable;
         end
         PIN_STATUS_OFS: begin
            rd_mux[CHANNELS-1:0]                        = channel_a_pin_i;
         end
         default: begin
            rd_mux = '0;
         end
      endcase

      // bus: ack one cycle after the request, write at the acked edge
      st_d.ack = bus_hit & ~st_q.ack;
      if (st_d.ack) begin
         st_d.rd_data = rd_mux;
      end
      if (bus_write) begin
         case (wb_req.adr)
            MODE_SELECT_OFS: begin
               st_d.phase_count_select    = wb_req.dat[PHASE_COUNT_BIT];
               st_d.flag_direction_select = wb_req.dat[FLAG_DIR_BIT];
               st_d.pulse_mode            = wb_req.dat[PULSE_MODE_LSB +: CHANNELS];
            end
            FUNC_CONTROL_OFS: begin
               st_d.combination_mode      = wb_req.dat[COMB_MODE_LSB +: 2];
               st_d.buffer_enable         = wb_req.dat[BUFFER_EN_LSB +: 4];
            end
            default: begin
               st_d.ack = st_d.ack;
            end
         endcase
      end
      if (standby) begin
         st_d.phase_count_select    = 1'b0;
         st_d.flag_direction_select = 1'b0;
         st_d.pulse_mode            = PULSE_MODE_RST;
         st_d.combination_mode      = COMB_MODE_RST;
         st_d.buffer_enable         = BUFFER_EN_RST;
      end

      // external count inputs: two flops then an edge register
      st_d.ext_a_meta = ext_count_in_a;
      st_d.ext_a_sync = st_q.ext_a_meta;
      st_d.ext_a_prev = st_q.ext_a_sync;
      st_d.ext_b_meta = ext_count_in_b;
      st_d.ext_b_sync = st_q.ext_b_meta;
      st_d.ext_b_prev = st_q.ext_b_sync;
      a_moved = st_q.ext_a_sync ^ st_q.ext_a_prev;
      b_moved = st_q.ext_b_sync ^ st_q.ext_b_prev;
      qstep   = quad_step(st_q.ext_a_sync, st_q.ext_b_sync, a_moved, b_moved);

      // count source: pins in phase mode, prescaler tick otherwise
      if (st_q.phase_count_select) begin
         step    = qstep[1];
         step_up = qstep[0];
      end else begin
         step    = count_tick_ch2;
         step_up = 1'b1;
      end
      step = step & count_run_ch2;

      // clear keeps priority in every mode
      st_d.overflow_set = 1'b0;
      if (counter_clear[2]) begin
         st_d.channel2_counter = COUNTER_MIN;
      end else if (step) begin
         if (step_up) begin
            wrap_up               = (st_q.channel2_counter == COUNTER_MAX);
            st_d.channel2_counter = st_q.channel2_counter + 16'h0001;
         end else begin
            wrap_down             = (st_q.channel2_counter == COUNTER_MIN);
            st_d.channel2_counter = st_q.channel2_counter - 16'h0001;
         end
         st_d.overflow_set = wrap_up | (wrap_down & ~st_q.flag_direction_select);
      end

      // pwm pin levels
      for (int i = 0; i < CHANNELS; i++) begin
         if (pwm_active[i]) begin
            if (match_a[i]) begin
               st_d.pin_level[i] = 1'b1;
            end else if (match_b[i]) begin
               st_d.pin_level[i] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign wb_rsp.ack          = st_q.ack;
   assign wb_rsp.dat          = st_q.rd_data;
   assign channel2_counter    = st_q.channel2_counter;
   assign overflow_flag_set   = st_q.overflow_set;
   assign phase_count_select  = st_q.phase_count_select;
   assign complementary_pwm   = (comb_mode == COMB_COMPLEMENTARY);
   assign reset_sync_pwm      = (comb_mode == COMB_RESET_SYNC);
   assign pwm_active[2:0]     = st_q.pulse_mode[2:0];
   assign pwm_active[4:3]     = (comb_mode == COMB_NORMAL) ? st_q.pulse_mode[4:3] : 2'h0;
   assign buffer_enable       = st_q.buffer_enable;
   assign channel_a_pin_o     = st_q.pin_level;
   assign channel_a_pin_oe_n  = ~pwm_active;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_phase_step;
      st_q.phase_count_select && count_run_ch2 && !counter_clear[2];
   endsequence

   sequence s_a_rise_b_low;
      !st_q.ext_a_prev && st_q.ext_a_sync && !b_moved && !st_q.ext_b_sync;
   endsequence

   sequence s_b_rise_a_low;
      !st_q.ext_b_prev && st_q.ext_b_sync && !a_moved && !st_q.ext_a_sync;
   endsequence

   a_phase_down_count: assert property (s_phase_step and s_a_rise_b_low
      |=> channel2_counter == $past(channel2_counter) - 16'h0001)
      else $error("phase count did not decrement");

   a_phase_up_count: assert property (s_phase_step and s_b_rise_a_low
      |=> channel2_counter == $past(channel2_counter) + 16'h0001)
      else $error("phase count did not increment");

   a_tick_ignored: assert property (s_phase_step ##0 (!a_moved && !b_moved && count_tick_ch2)
      |=> $stable(channel2_counter))
      else $error("prescaler tick moved counter in phase mode");

   a_clear_phase: assert property (st_q.phase_count_select && counter_clear[2]
      |=> channel2_counter == 16'h0000 && !overflow_flag_set)
      else $error("clear lost in phase mode");

   a_underflow_flag: assert property (s_phase_step
      ##0 (step && !step_up && channel2_counter == 16'h0000)
      |=> channel2_counter == 16'hFFFF && overflow_flag_set == !st_q.flag_direction_select)
      else $error("underflow flag wrong for flag direction");

   a_overflow_flag: assert property (!counter_clear[2] && step && step_up && channel2_counter == 16'hFFFF
      |=> channel2_counter == 16'h0000 && overflow_flag_set)
      else $error("overflow not flagged");

   a_pwm_levels: assert property (pwm_active[0] && match_a[0]
      ##1 pwm_active[0] && match_b[0] && !match_a[0]
      |-> channel_a_pin_o[0] ##1 !channel_a_pin_o[0] && !channel_a_pin_oe_n[0])
      else $error("pwm pin levels wrong");

   a_comb_mask: assert property (st_q.combination_mode[1] |-> pwm_active[4:3] == 2'h0
      && (complementary_pwm ^ reset_sync_pwm))
      else $error("combination mode did not override pulse mode");

   a_init_values: assert property ($past(standby) |-> st_q.pulse_mode == 5'h00
      && st_q.combination_mode == 2'h0 && buffer_enable == 4'h0 && !phase_count_select
      && !st_q.flag_direction_select)
      else $error("standby did not clear mode bits");

   a_sync_clear: assert property (clear_request[0] && timer_sync_select[0] && timer_sync_select[2]
      |-> counter_clear[2] ##1 channel2_counter == 16'h0000)
      else $error("synchronized clear missed channel 2");

   a_func_readback: assert property (bus_hit && !st_q.ack && !wb_req.we && wb_req.adr == FUNC_CONTROL_OFS
      |=> wb_rsp.ack && wb_rsp.dat[7:6] == 2'h1)
      else $error("fixed bit of function control wrong");

   a_tick_count: assert property (!st_q.phase_count_select && count_run_ch2 && count_tick_ch2
      && !counter_clear[2] |=> channel2_counter == $past(channel2_counter) + 16'h0001)
      else $error("prescaler tick did not count in normal mode");

   a_pins_ignored: assert property (!st_q.phase_count_select && !count_tick_ch2 && !counter_clear[2]
      |=> $stable(channel2_counter))
      else $error("counter moved without a tick in normal mode");

   a_mode_write: assert property (bus_write && wb_req.adr == MODE_SELECT_OFS && !standby
      |=> st_q.flag_direction_select == $past(wb_req.dat[FLAG_DIR_BIT])
      && phase_count_select == $past(wb_req.dat[PHASE_COUNT_BIT])
      && st_q.pulse_mode == $past(wb_req.dat[PULSE_MODE_LSB +: CHANNELS]))
      else $error("mode select write lost");

   a_buffer_write: assert property (bus_write && wb_req.adr == FUNC_CONTROL_OFS && !standby
      |=> buffer_enable == $past(wb_req.dat[BUFFER_EN_LSB +: 4])
      && st_q.combination_mode == $past(wb_req.dat[COMB_MODE_LSB +: 2]))
      else $error("function control write lost");

   a_comb_normal: assert property (!st_q.combination_mode[1]
      |-> pwm_active == st_q.pulse_mode && !complementary_pwm && !reset_sync_pwm)
      else $error("normal combination mode changed pulse mode");

   a_pin_hold: assert property (!pwm_active[0]
      |=> channel_a_pin_o[0] == $past(channel_a_pin_o[0]))
      else $error("released pin level changed");

   a_sync_chain: assert property (!$past(rst) && !$past(rst, 2)
      |-> st_q.ext_a_sync == $past(ext_count_in_a, 2) && st_q.ext_b_sync == $past(ext_count_in_b, 2))
      else $error("count input synchroniser delay wrong");

endmodule : timer_mode_pwm_control

// ### testbench/quad_encoder_model.sv
// Purpose: far side of the timer slice: quadrature encoder and the channel A pin loads
// Assumes: steps are commanded by the bench just after a rising clock edge
// Notes:   a released pin shows the inverse of the level last driven on it
module quad_encoder_model (
   // clock
   input  wire logic       clk_sys,
   // pin loads
   input  wire logic [4:0] pin_o,
   input  wire logic [4:0] pin_oe_n,
   output logic      [4:0] pin_i,
   // encoder outputs
   output logic            ext_a,
   output logic            ext_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_q = 2'h0;

   // gray order 00, 01, 11, 10 counts up
   assign {ext_a, ext_b} = phase_q ^ {1'b0, phase_q[1]};
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ~pin_o);

   // one quadrature step, then levels stand still for hold cycles
   task automatic step(input logic up, input int hold);
      phase_q <= up ? phase_q + 2'h1 : phase_q - 2'h1;
      repeat (hold) @(posedge clk_sys);
   endtask : step
endmodule : quad_encoder_model

// ### testbench/tb_timer_mode_pwm_control.sv
// Purpose: self-checking bench of the timer mode and pwm control slice
// Assumes: classic wishbone master, seed fixed at 10
// Notes:   expectations are computed here from the field layout
module tb_timer_mode_pwm_control;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_mode_pkg::*;
   logic        clk_sys = 0, rst = 1, standby = 0, run = 0, tick = 0;
   wb_req_s     wb_req = '0;
   wb_rsp_s     wb_rsp;
   logic        ext_a, ext_b, ovf, pcs, comp, rsy, up;
   logic [15:0] cnt, exp_cnt;
   logic [4:0]  sync = 0, clr = 0, ma = 0, mb = 0, cclr, pin_i, pin_o, oe_n, pwm, ep;
   logic [3:0]  buf_en;
   logic [7:0]  m, f;
   int          err_total = 0, samples_checked = 0, seed = 10, ovf_seen = 0, exp_ovf;

   timer_mode_pwm_control dut_u (.clk_sys(clk_sys), .rst(rst), .standby(standby), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .ext_count_in_a(ext_a), .ext_count_in_b(ext_b), .count_run_ch2(run),
      .count_tick_ch2(tick), .channel2_counter(cnt), .overflow_flag_set(ovf), .timer_sync_select(sync),
      .clear_request(clr), .counter_clear(cclr), .match_a(ma), .match_b(mb), .channel_a_pin_i(pin_i),
      .channel_a_pin_o(pin_o), .channel_a_pin_oe_n(oe_n), .phase_count_select(pcs), .pwm_active(pwm),
      .complementary_pwm(comp), .reset_sync_pwm(rsy), .buffer_enable(buf_en));
   quad_encoder_model enc_u (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe_n(oe_n), .pin_i(pin_i),
      .ext_a(ext_a), .ext_b(ext_b));

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (ovf === 1'b1) ovf_seen++;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 20);
      q = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk_sys);
      if (n >= 20) begin
         err_total++;
         $display("MISMATCH t=%0t bus ack timeout", $time);
         results();
      end
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, {24'h0, d}, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e, what);
   endtask : rd

   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(MODE_SELECT_OFS, 32'h0, "mode reset");
      rd(FUNC_CONTROL_OFS, 32'h40, "func reset");
      rd(8'h0C, 32'h0, "unmapped read");
      $display("test reset values done");
      // counter stopped and sync bits clear while combination modes are set
      for (int i = 0; i < 12; i++) begin
         m = 8'($random(seed));
         f = 8'($random(seed));
         if (i < 4) f[5:4] = 2'(i);
         f[6] = 1'b1;
         wr(MODE_SELECT_OFS, m);
         wr(FUNC_CONTROL_OFS, f);
         rd(MODE_SELECT_OFS, {25'h0, m[6:0]}, "mode readback");
         rd(FUNC_CONTROL_OFS, {26'h1, f[5:0]}, "func readback");
         ep = f[5] ? {2'b00, m[2:0]} : m[4:0];
         chk(32'(pwm), 32'(ep), "pwm active");
         chk(32'(oe_n), {27'h0, ~ep}, "pin enable");
         chk(32'({comp, rsy}), 32'({f[5] & ~f[4], f[5] & f[4]}), "comb decode");
         chk(32'(buf_en), 32'(f[3:0]), "buffer enables");
         chk(32'(pcs), 32'(m[6]), "phase select");
      end
      standby <= 1'b1;
      @(posedge clk_sys);
      standby <= 1'b0;
      @(posedge clk_sys);
      rd(MODE_SELECT_OFS, 32'h0, "mode standby");
      rd(FUNC_CONTROL_OFS, 32'h40, "func standby");
      $display("test register fields done");
      for (int fd = 0; fd < 2; fd++) begin
         wr(MODE_SELECT_OFS, {2'b01, 1'(fd), 5'h00});
         clr <= 5'h04;
         @(posedge clk_sys);
         clr <= 5'h00;
         run <= 1'b1;
         repeat (3) @(posedge clk_sys);
         exp_cnt = 16'h0000;
         exp_ovf = 0;
         ovf_seen = 0;
         for (int j = 0; j < 42; j++) begin
            up = (j == 0) ? 1'b0 : (j == 1) ? 1'b1 : 1'($random(seed));
            if (up && exp_cnt == COUNTER_MAX) exp_ovf++;
            if (!up && exp_cnt == COUNTER_MIN && fd == 0) exp_ovf++;
            exp_cnt = up ? exp_cnt + 16'h1 : exp_cnt - 16'h1;
            enc_u.step(up, 6);
            chk(32'(cnt), 32'(exp_cnt), "phase count");
         end
         tick <= 1'b1;
         repeat (4) @(posedge clk_sys);
         tick <= 1'b0;
         repeat (2) @(posedge clk_sys);
         chk(32'(cnt), 32'(exp_cnt), "tick ignored");
         chk(32'(ovf_seen), 32'(exp_ovf), "overflow pulses");
         clr <= 5'h04;
         @(posedge clk_sys);
         clr <= 5'h00;
         repeat (2) @(posedge clk_sys);
         chk(32'(cnt), 32'h0, "clear in phase mode");
         run <= 1'b0;
      end
      $display("test phase counting done");
      // one step down to FFFF, then a prescaler tick in normal mode wraps it
      @(posedge clk_sys);
      run <= 1'b1;
      enc_u.step(1'b0, 6);
      chk(32'(cnt), 32'hFFFF, "underflow step");
      wr(MODE_SELECT_OFS, 8'h20);
      ovf_seen = 0;
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(32'(cnt), 32'h0, "tick count in normal mode");
      chk(32'(ovf_seen), 32'h1, "overflow in normal mode");
      enc_u.step(1'b1, 6);
      chk(32'(cnt), 32'h0, "pins ignored in normal mode");
      run <= 1'b0;
      $display("test normal counting done");
      wr(MODE_SELECT_OFS, 8'h1F);
      for (int ch = 0; ch < CHANNELS; ch++) begin
         ma <= 5'(1 << ch);
         @(posedge clk_sys);
         ma <= 5'h00;
         @(posedge clk_sys);
         chk(32'(pin_o[ch]), 32'h1, "pin set on match a");
         mb <= 5'(1 << ch);
         @(posedge clk_sys);
         mb <= 5'h00;
         @(posedge clk_sys);
         chk(32'(pin_o[ch]), 32'h0, "pin clear on match b");
      end
      // match b straight after match a
      ma <= 5'h01;
      @(posedge clk_sys);
      ma <= 5'h00;
      mb <= 5'h01;
      @(posedge clk_sys);
      chk(32'(pin_o[0]), 32'h1, "pin set before match b");
      mb <= 5'h00;
      @(posedge clk_sys);
      chk(32'(pin_o[0]), 32'h0, "match b right after match a");
      ma <= 5'h1F;
      @(posedge clk_sys);
      ma <= 5'h00;
      @(posedge clk_sys);
      rd(PIN_STATUS_OFS, 32'h1F, "pin status");
      wr(MODE_SELECT_OFS, 8'h00);
      rd(PIN_STATUS_OFS, 32'h00, "released pins");
      $display("test pwm pins done");
      for (int k = 0; k < 10; k++) begin
         sync <= 5'($random(seed));
         clr <= 5'($random(seed));
         @(posedge clk_sys);
         chk(32'(cclr), 32'(clr | (sync & {5{|(clr & sync)}})), "sync clear");
      end
      clr <= 5'h00;
      $display("test sync clear done");
      results();
   end
endmodule : tb_timer_mode_pwm_control
